// File: design/event_monitor_pkg.sv
// Constants and carrier types for the input event monitor
package event_monitor_pkg;
  localparam int NUM_CH = 64;
  localparam int CH_W = 6;
  localparam int TIME_W = 16;
  localparam int CNT_W = 16;
  localparam int LOG_DEPTH = 3072;
  localparam int LOG_AW = 12;
  localparam int DEB_W = 10;
  localparam int CLK_HZ = 10000000;
  localparam int MS_PER_S = 1000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYC = (CLK_HZ / MS_PER_S) * TICK_MS;
  localparam int TICK_W = 14;
  localparam logic [15:0] TIME_RST = 16'h0000;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [7:0] VEC_RST = 8'h00;
  localparam logic [2:0] LVL_RST = 3'h0;
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [5:0] AM_A24_NP = 6'h39;
  localparam logic [5:0] AM_A24_SU = 6'h3d;
  localparam logic [5:0] AM_A16_NP = 6'h29;
  localparam logic [5:0] AM_A16_SU = 6'h2d;
  localparam int A24_BASE_LSB = 16;
  localparam int A16_BASE_LSB = 12;

  typedef enum logic [1:0] {ST_TEST, ST_CLEAR, ST_RUN} phase_t;

  // Per-channel software configuration
  typedef struct packed {
    logic [1:0] edge_sel;
    logic log_en;
    logic [DEB_W-1:0] debounce_ms;
  } ch_cfg_t;

  // One logged entry
  typedef struct packed {
    logic [CH_W-1:0] ch;
    logic [TIME_W-1:0] stamp;
  } log_entry_t;

  // Bus request decoded from the backplane
  typedef struct packed {
    logic strobe;
    logic [23:0] addr;
    logic [5:0] am;
  } bus_req_t;

  // Jumper settings
  typedef struct packed {
    logic a24_sel;
    logic np_en;
    logic su_en;
    logic [7:0] base;
  } jumper_t;
endpackage

// File: design/event_monitor.sv
// Input event monitor core: edge detect, debounce, counters, event log, interrupter
//
// Function
// R1: Per channel, detect rising, falling, both or no edges as selected.
// R2: Log selected events with a millisecond relative timer up to 65535; code logs only the lowest channel per tick, none in a buffer-request cycle.
// R3: A host timer reset restarts the millisecond count at zero.
// R4: Each channel keeps a 16-bit pulse counter of qualifying changes.
// R5: Interrupt may be requested on any bus level chosen by software.
// R6: During acknowledge of our level, drive the 8-bit vector.
// R7: Release the interrupt request during the acknowledge cycle itself.
// R8: Decode base address in A24 or A16 space per jumpers.
// R9: Accept nonprivileged, supervisory or both address modifiers per jumpers.
// R10: Self-test runs after every reset, then sets test-complete flag.
// R11: Reset turns fail indicator on, disables interrupts, clears flags, vector; code sets the test-mode flag on.
// R12: Reset clears edge-select, counter-irq, debounce/select and pulse counters.
// R13: Reset loads timer with zero and holds it stopped.
// R14: Reset clears log threshold count and current log count.
// R15: Failed test leaves test data in buffers; passed test clears them.
// R16: Debounce each input with its own programmed time.
// R17: Event timer advances once per millisecond.
// R18: Two 3072-entry log buffers; log into one while host reads other.
// R19: Buffer request swaps buffers, copies count to index, zeroes count.
// R20: With counter irq enable, interrupt when a pulse counter rolls to zero.
`timescale 1ns/1ps
`default_nettype none
module event_monitor
  import event_monitor_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input wire logic clk_i, // 10 MHz clock
  input wire logic rstn_i, // Async reset, active low
  input wire logic en_i, // Clock enable
  input wire logic [NUM_CH-1:0] din_i, // Field inputs
  input wire event_monitor_pkg::ch_cfg_t [NUM_CH-1:0] cfg_i, // Per-channel config
  input wire logic [NUM_CH-1:0] counter_irq_enable_i, // Rollover irq enables
  input wire logic cfg_we_i, // Config load strobe
  input wire event_monitor_pkg::jumper_t jumper_i, // Address jumpers
  input wire event_monitor_pkg::bus_req_t bus_i, // Backplane address phase
  output logic sel_o, // Board selected
  input wire logic timer_run_i, // Start event timer
  input wire logic timer_reset_i, // Host timer reset pulse
  input wire logic buf_req_i, // Buffer-request write pulse
  input wire logic [LOG_AW-1:0] rd_addr_i, // Host read index
  output event_monitor_pkg::log_entry_t rd_data_o, // Host read entry
  input wire logic [2:0] irq_level_i, // Software irq level, 0 off
  input wire logic [7:0] irq_vector_i, // Vector value
  input wire logic vec_we_i, // Vector/level load strobe
  input wire logic [CNT_W-1:0] log_threshold_i, // Log threshold count
  input wire logic thr_we_i, // Threshold load strobe
  input wire logic test_disable_i, // Leave test mode
  input wire logic test_fail_i, // Self-test result
  input wire logic iack_i, // Acknowledge cycle strobe
  input wire logic [2:0] iack_level_i, // Level being acknowledged
  output logic [7:0] vec_data_o, // Vector on data lines
  output logic vec_oe_o, // Vector drive enable
  output logic [7:1] irq_n_o, // Interrupt request lines, low active
  output logic test_done_o, // Self-test complete flag
  output logic test_mode_o, // Test mode flag
  output logic fail_led_o, // Fail indicator
  output logic [CNT_W-1:0] log_count_o, // Current log count
  output logic [CNT_W-1:0] log_index_o, // Count captured at buffer request
  output logic [TIME_W-1:0] timer_o, // Event timer
  output logic [NUM_CH-1:0] state_o, // Debounced inputs
  output logic [CNT_W-1:0] pulse_count_o [NUM_CH] // Pulse counters
);

  typedef struct packed {
    phase_t phase;
    logic [LOG_AW:0] clr_addr;
    logic [TICK_W-1:0] tick_cnt;
    logic [TIME_W-1:0] timer;
    logic timer_run;
    logic [NUM_CH-1:0] deb_state;
    logic [NUM_CH-1:0][DEB_W-1:0] deb_cnt;
    ch_cfg_t [NUM_CH-1:0] cfg;
    logic [NUM_CH-1:0] cnt_irq_en;
    logic [NUM_CH-1:0][CNT_W-1:0] pulse;
    logic wr_bank;
    logic [LOG_AW-1:0] wr_ptr;
    logic [CNT_W-1:0] log_count;
    logic [CNT_W-1:0] log_index;
    logic [CNT_W-1:0] log_thr;
    logic [2:0] irq_level;
    logic [7:0] vector;
    logic irq_pend;
    logic test_done;
    logic test_mode;
    logic fail_led;
    logic [7:0] vec_data;
    logic vec_oe;
  } state_t;

  state_t q, d;
  log_entry_t mem [2*LOG_DEPTH];
  logic mem_we;
  logic [LOG_AW:0] mem_waddr;
  log_entry_t mem_wdata;
  logic tick;
  logic [NUM_CH-1:0] ev;
  logic [CH_W-1:0] ev_ch;
  logic ev_any;
  logic [5:0] am_np, am_su;
  logic a24_hit, a16_hit;

  // Address and modifier decode
  always_comb begin
    am_np = jumper_i.a24_sel ? AM_A24_NP : AM_A16_NP; // R8
    am_su = jumper_i.a24_sel ? AM_A24_SU : AM_A16_SU; // R8
    a24_hit = bus_i.addr[23:A24_BASE_LSB] == jumper_i.base; // R8
    a16_hit = bus_i.addr[15:A16_BASE_LSB] == jumper_i.base[3:0]; // R8
    sel_o = 1'b0;
    if (bus_i.strobe && ((jumper_i.np_en && bus_i.am == am_np) ||
        (jumper_i.su_en && bus_i.am == am_su))) begin // R9
      sel_o = jumper_i.a24_sel ? a24_hit : a16_hit; // R8
    end
  end

  assign tick = q.tick_cnt == TICK_W'(TICK_CYCLES - 1); // R17

  always_comb begin
    d = q;
    ev = '0;
    ev_ch = '0;
    ev_any = 1'b0;
    mem_we = 1'b0;
    mem_waddr = '0;
    mem_wdata = '0;
    d.vec_oe = 1'b0;
    case (q.phase)
      ST_TEST: begin
        // Self-test pattern written into every entry of both banks
        mem_we = 1'b1;
        mem_waddr = q.clr_addr;
        mem_wdata = {CH_W'(q.clr_addr[CH_W-1:0]), TIME_W'(16'ha5a5)};
        d.clr_addr = q.clr_addr + 1'b1;
        if (q.clr_addr == (LOG_AW+1)'(2*LOG_DEPTH-1)) begin
          d.clr_addr = '0;
          d.phase = test_fail_i ? ST_RUN : ST_CLEAR; // R15
          d.test_done = test_fail_i; // R10
        end
      end
      ST_CLEAR: begin
        mem_we = 1'b1; // R15
        mem_waddr = q.clr_addr;
        d.clr_addr = q.clr_addr + 1'b1;
        if (q.clr_addr == (LOG_AW+1)'(2*LOG_DEPTH-1)) begin
          d.phase = ST_RUN;
          d.test_done = 1'b1; // R10
          d.fail_led = 1'b0;
        end
      end
      default: begin
        d.tick_cnt = tick ? '0 : q.tick_cnt + 1'b1;
        if (timer_run_i) begin
          d.timer_run = 1'b1;
        end
        if (timer_reset_i) begin
          d.timer = '0; // R3
        end else if (tick && q.timer_run) begin
          d.timer = q.timer + 1'b1; // R2 R17
        end
        if (cfg_we_i) begin
          d.cfg = cfg_i;
          d.cnt_irq_en = counter_irq_enable_i;
        end
        if (vec_we_i) begin
          d.irq_level = irq_level_i; // R5
          d.vector = irq_vector_i;
        end
        if (thr_we_i) begin
          d.log_thr = log_threshold_i;
        end
        if (test_disable_i) begin
          d.test_mode = 1'b0;
        end
        for (int i = 0; i < NUM_CH; i++) begin
          if (tick) begin
            if (din_i[i] == q.deb_state[i]) begin
              d.deb_cnt[i] = '0;
            end else if (q.deb_cnt[i] >= q.cfg[i].debounce_ms) begin // R16
              d.deb_cnt[i] = '0;
              d.deb_state[i] = din_i[i];
              ev[i] = (din_i[i] && q.cfg[i].edge_sel[0]) ||
                      (!din_i[i] && q.cfg[i].edge_sel[1]); // R1
            end else begin
              d.deb_cnt[i] = q.deb_cnt[i] + 1'b1;
            end
          end
          if (ev[i]) begin
            d.pulse[i] = q.pulse[i] + 1'b1; // R4
            if (q.cnt_irq_en[i] && q.pulse[i] == 16'hffff) begin
              d.irq_pend = 1'b1; // R20
            end
          end
        end
        // Lowest logging channel with an event this tick
        for (int i = NUM_CH - 1; i >= 0; i--) begin
          if (ev[i] && q.cfg[i].log_en) begin
            ev_any = 1'b1;
            ev_ch = CH_W'(i);
          end
        end
        if (buf_req_i) begin
          d.wr_bank = ~q.wr_bank; // R18 R19
          d.wr_ptr = '0;
          d.log_index = q.log_count; // R19
          d.log_count = '0; // R19
        end else if (ev_any) begin
          mem_we = 1'b1; // R2
          // Bank 1 starts right after bank 0, not at a power of two
          mem_waddr = (q.wr_bank ? (LOG_AW+1)'(LOG_DEPTH) : '0) + (LOG_AW+1)'(q.wr_ptr);
          mem_wdata = '{ch: ev_ch, stamp: q.timer};
          d.wr_ptr = (q.wr_ptr == LOG_AW'(LOG_DEPTH-1)) ? '0 : q.wr_ptr + 1'b1;
          d.log_count = (q.log_count == CNT_W'(LOG_DEPTH)) ? '0 : q.log_count + 1'b1;
          if (q.log_thr != '0 && q.log_count + 1'b1 == q.log_thr) begin
            d.irq_pend = 1'b1;
          end
        end
        if (q.irq_level == LVL_RST) begin
          d.irq_pend = 1'b0;
        end
        if (iack_i && q.irq_pend && iack_level_i == q.irq_level) begin
          d.vec_data = q.vector; // R6
          d.vec_oe = 1'b1; // R6
          d.irq_pend = 1'b0; // R7
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q <= '0; // R12 R14
      q.phase <= ST_TEST; // R10
      q.timer <= TIME_RST; // R13
      q.timer_run <= 1'b0; // R13
      q.irq_level <= LVL_RST; // R11
      q.vector <= VEC_RST; // R11
      q.test_mode <= 1'b1; // R11
      q.fail_led <= 1'b1; // R11
    end else if (en_i) begin
      q <= d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (en_i && mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
    if (en_i) begin
      rd_data_o <= mem[(q.wr_bank ? '0 : (LOG_AW+1)'(LOG_DEPTH)) + (LOG_AW+1)'(rd_addr_i)]; // R18
    end
  end

  always_comb begin
    irq_n_o = '1;
    for (int l = 1; l < 8; l++) begin
      if (q.irq_pend && q.irq_level == 3'(l)) begin
        irq_n_o[l] = 1'b0; // R5
      end
    end
    for (int i = 0; i < NUM_CH; i++) begin
      pulse_count_o[i] = q.pulse[i];
    end
  end

  assign vec_data_o = q.vec_data;
  assign vec_oe_o = q.vec_oe;
  assign test_done_o = q.test_done;
  assign test_mode_o = q.test_mode;
  assign fail_led_o = q.fail_led;
  assign log_count_o = q.log_count;
  assign log_index_o = q.log_index;
  assign timer_o = q.timer;
  assign state_o = q.deb_state;

endmodule
`default_nettype wire

// File: tb/event_monitor_chk.sv
// Port assertions for the input event monitor
`timescale 1ns/1ps
`default_nettype none
module event_monitor_chk
  import event_monitor_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input wire logic clk_i, // Clock
  input wire logic rstn_i, // Reset
  input wire event_monitor_pkg::jumper_t jumper_i, // Jumpers
  input wire event_monitor_pkg::bus_req_t bus_i, // Bus
  input wire logic sel_o, // Select
  input wire logic timer_reset_i, // Timer clear
  input wire logic buf_req_i, // Bank swap
  input wire logic iack_i, // Ack
  input wire logic [2:0] iack_level_i, // Ack level
  input wire logic vec_oe_o, // Vector drive
  input wire logic [7:1] irq_n_o, // Requests
  input wire logic test_done_o, // Test done
  input wire logic test_mode_o, // Test mode
  input wire logic fail_led_o, // Fail
  input wire logic [CNT_W-1:0] log_count_o, // Count
  input wire logic [CNT_W-1:0] log_index_o, // Index
  input wire logic [TIME_W-1:0] timer_o // Timer
);
  logic run;
  assign run = test_done_o && !fail_led_o;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  sequence s_ack;
    iack_i && iack_level_i != 3'h0 && !irq_n_o[iack_level_i];
  endsequence
  a_reset_defaults:
    assert property ($rose(rstn_i) |-> fail_led_o && test_mode_o && irq_n_o == 7'h7f
      && timer_o == '0 && log_count_o == '0) else $error("bad reset state");
  a_ack_vector:
    assert property (s_ack |=> vec_oe_o ##1 !vec_oe_o) else $error("bad vector drive");
  a_ack_release:
    assert property (s_ack |=> irq_n_o[$past(iack_level_i)]) else $error("request held");
  a_one_level:
    assert property ($countones(~irq_n_o) <= 1) else $error("several levels");
  a_bank_swap:
    assert property (buf_req_i && run |=> log_count_o == '0
      && log_index_o == $past(log_count_o)) else $error("bad bank swap");
  a_timer_clear:
    assert property (timer_reset_i && run |=> timer_o == '0) else $error("timer not cleared");
  a_timer_step:
    assert property ($changed(timer_o) |-> timer_o == $past(timer_o) + 16'h1
      || timer_o == '0) else $error("timer jump");
  a_sel_decode:
    assert property (bus_i.strobe && bus_i.am == AM_A24_NP && jumper_i.a24_sel && jumper_i.np_en
      && bus_i.addr[23:16] == jumper_i.base |-> sel_o) else $error("no select");
endmodule
bind event_monitor event_monitor_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.clk_i, .rstn_i,
  .jumper_i, .bus_i, .sel_o, .timer_reset_i, .buf_req_i, .iack_i, .iack_level_i, .vec_oe_o,
  .irq_n_o, .test_done_o, .test_mode_o, .fail_led_o, .log_count_o, .log_index_o, .timer_o);
`default_nettype wire

// File: tb/host_ack.sv
// Host model that acknowledges bus interrupts
`timescale 1ns/1ps
`default_nettype none
module host_ack (
  input wire logic clk_i, // Clock
  input wire logic rstn_i, // Reset
  input wire logic slow_i, // Late answer
  input wire logic [7:1] irq_n_i, // Requests
  output logic iack_o, // Ack strobe
  output logic [2:0] iack_level_o // Ack level
);
  logic [3:0] wait_q;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wait_q <= 4'h0;
      iack_o <= 1'b0;
      iack_level_o <= 3'h0;
    end else begin
      iack_o <= 1'b0;
      if (iack_o || &irq_n_i) begin
        wait_q <= 4'h0;
      end else if (wait_q == (slow_i ? 4'h8 : 4'h1)) begin
        iack_o <= 1'b1;
        for (int l = 1; l < 8; l++) if (!irq_n_i[l]) iack_level_o <= 3'(l);
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/event_monitor_tb.sv
// Self-checking bench for the input event monitor
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
  $display("ERROR %0t got %h want %h", $time, a, b); end end
module event_monitor_tb;
  import event_monitor_pkg::*;
  logic clk_i, rstn_i, en_i, cfg_we_i, timer_run_i, timer_reset_i, buf_req_i, vec_we_i;
  logic thr_we_i, test_disable_i, test_fail_i, iack_i, sel_o, vec_oe_o, test_done_o;
  logic test_mode_o, fail_led_o;
  logic [NUM_CH-1:0] din_i, counter_irq_enable_i, state_o;
  ch_cfg_t [NUM_CH-1:0] cfg_i;
  jumper_t jumper_i;
  bus_req_t bus_i;
  logic [LOG_AW-1:0] rd_addr_i;
  log_entry_t rd_data_o;
  logic [2:0] irq_level_i, iack_level_i;
  logic [7:0] irq_vector_i, vec_data_o;
  logic [CNT_W-1:0] log_threshold_i, log_count_o, log_index_o, timer_o;
  logic [7:1] irq_n_o;
  logic [CNT_W-1:0] pulse_count_o [NUM_CH];
  logic [CNT_W-1:0] exp_pc [6] = '{16'h0, 16'h1, 16'h1, 16'h2, 16'h0, 16'h0};
  int errors = 0;
  int checks_done = 0;
  event_monitor #(.TICK_CYCLES(10)) dut (.clk_i, .rstn_i, .en_i, .din_i, .cfg_i,
    .counter_irq_enable_i, .cfg_we_i, .jumper_i, .bus_i, .sel_o, .timer_run_i, .timer_reset_i,
    .buf_req_i, .rd_addr_i, .rd_data_o, .irq_level_i, .irq_vector_i, .vec_we_i,
    .log_threshold_i, .thr_we_i, .test_disable_i, .test_fail_i, .iack_i, .iack_level_i,
    .vec_data_o, .vec_oe_o, .irq_n_o, .test_done_o, .test_mode_o, .fail_led_o, .log_count_o,
    .log_index_o, .timer_o, .state_o, .pulse_count_o);
  host_ack host (.clk_i, .rstn_i, .slow_i(1'b1), .irq_n_i(irq_n_o), .iack_o(iack_i),
    .iack_level_o(iack_level_i));
  task automatic final_report;
    $display("Checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  localparam int S_RUN = 0;
  localparam int S_TRST = 1;
  localparam int S_CFG = 2;
  localparam int S_VEC = 3;
  localparam int S_THR = 4;
  localparam int S_BUF = 5;
  // Drives one strobe by index, no writes through references
  task automatic set_strobe(input int k, input logic v);
    case (k)
      S_RUN: timer_run_i <= v;
      S_TRST: timer_reset_i <= v;
      S_CFG: cfg_we_i <= v;
      S_VEC: vec_we_i <= v;
      S_THR: thr_we_i <= v;
      default: buf_req_i <= v;
    endcase
  endtask
  task automatic pulse(input int k);
    set_strobe(k, 1'b1);
    @(posedge clk_i);
    set_strobe(k, 1'b0);
    @(posedge clk_i);
  endtask
  task automatic sel_case(jumper_t j, logic [23:0] a, logic [5:0] m, logic e);
    jumper_i <= j;
    bus_i <= '{1'b1, a, m};
    @(posedge clk_i);
    `CHK(sel_o, e)
  endtask
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    $display("ERROR %0t watchdog expired", $time);
    final_report();
  end
  initial begin
    {rstn_i, cfg_we_i, timer_run_i, timer_reset_i, buf_req_i, vec_we_i, thr_we_i} = '0;
    {test_disable_i, test_fail_i, din_i, counter_irq_enable_i, rd_addr_i} = '0;
    {en_i, jumper_i, bus_i, cfg_i} = {1'b1, 11'h0, 31'h0, 832'h0};
    {irq_level_i, irq_vector_i, log_threshold_i} = {3'h3, 8'h5a, 16'h1};
    repeat (3) @(posedge clk_i);
    `CHK({fail_led_o, test_mode_o, irq_n_o}, 9'h1ff)
    `CHK({timer_o, log_count_o, pulse_count_o[9]}, 48'h0)
    rstn_i <= 1'b1;
    for (int i = 0; i < 13000 && test_done_o !== 1'b1; i++) @(posedge clk_i);
    `CHK({test_done_o, test_mode_o}, 2'h3)
    `CHK({fail_led_o, timer_o}, 17'h0)
    rd_addr_i <= 12'h5;
    repeat (2) @(posedge clk_i);
    `CHK(rd_data_o, 22'h0)
    $display("Test reset done");
    sel_case('{1'b1, 1'b1, 1'b0, 8'h12}, 24'h123456, AM_A24_NP, 1'b1);
    sel_case('{1'b1, 1'b1, 1'b0, 8'h12}, 24'h123456, AM_A24_SU, 1'b0);
    sel_case('{1'b1, 1'b1, 1'b0, 8'h12}, 24'h133456, AM_A24_NP, 1'b0);
    sel_case('{1'b0, 1'b0, 1'b1, 8'h02}, 24'h002abc, AM_A16_SU, 1'b1);
    bus_i <= '0;
    pulse(S_RUN);
    repeat (50) @(posedge clk_i);
    `CHK(timer_o inside {16'h4, 16'h5, 16'h6}, 1'b1)
    pulse(S_TRST);
    `CHK(timer_o, 16'h0)
    $display("Test decode and timer done");
    for (int c = 0; c < NUM_CH; c++) cfg_i[c] <= '{c[1:0], c == 1, (c == 5) ? 10'd10 : 10'd0};
    pulse(S_CFG);
    pulse(S_VEC);
    pulse(S_THR);
    din_i <= '1;
    for (int i = 0; i < 40 && irq_n_o === 7'h7f; i++) @(posedge clk_i);
    `CHK(irq_n_o, 7'h7b)
    for (int i = 0; i < 20 && vec_oe_o !== 1'b1; i++) @(posedge clk_i);
    `CHK({vec_oe_o, vec_data_o}, 9'h15a)
    @(posedge clk_i);
    `CHK(irq_n_o, 7'h7f)
    repeat (30) @(posedge clk_i);
    din_i <= '0;
    repeat (60) @(posedge clk_i);
    for (int c = 0; c < 6; c++) `CHK(pulse_count_o[c], exp_pc[c])
    `CHK(log_count_o, 16'h1)
    pulse(S_BUF);
    `CHK({log_index_o, log_count_o}, 32'h10000)
    rd_addr_i <= 12'h0;
    repeat (2) @(posedge clk_i);
    `CHK(rd_data_o.ch, 6'h1)
    $display("Test channels done");
    final_report();
  end
endmodule
`default_nettype wire
